// [include/gdio_pkg.sv]
// Package with register map, field layout and bus carriers of the general digital I/O port
// Functional notes
// - Direction bit one makes pin an output
// - Pull-up only for input, latch one, enabled
// - Output pin drives latch value, pull-up off
// - Global disable bit kills every pull-up
// - Reset tri-states all pins asynchronously
// - Latch, direction, input registers per port
// - Input register reads pins, writes store nothing
// - Writing one to input bit toggles latch
// - Bit set/clear touches only that pin
// - Alternate functions leave other pins usable
// - Pin level readable whatever its direction
// - Input passes a two stage synchronizer
// - Deep sleep clamps inputs unless exempted
package gdio_pkg;
   localparam int GDIO_NUM_PORTS = 2;
   localparam int GDIO_PIN_W = 8;
   localparam int GDIO_ADDR_W = 12;
   localparam int GDIO_DATA_W = 32;
   localparam int GDIO_SYNC_STAGES = 2;

   // Per-port block of registers; port n sits at n times the stride
   localparam logic [11:0] GDIO_PORT_STRIDE = 12'h020;
   localparam logic [11:0] GDIO_OFF_LATCH = 12'h000;
   localparam logic [11:0] GDIO_OFF_DIR = 12'h004;
   localparam logic [11:0] GDIO_OFF_INPUT = 12'h008;
   localparam logic [11:0] GDIO_OFF_LATCH_SET = 12'h00c;
   localparam logic [11:0] GDIO_OFF_LATCH_CLR = 12'h010;
   localparam logic [11:0] GDIO_OFF_DIR_SET = 12'h014;
   localparam logic [11:0] GDIO_OFF_DIR_CLR = 12'h018;
   localparam logic [11:0] GDIO_OFF_MCU_CONTROL = 12'h100;

   // Control register fields
   localparam int GDIO_MCU_SCAN_DIS_BIT = 7;
   localparam int GDIO_MCU_PUD_BIT = 4;
   localparam int GDIO_MCU_VEC_SEL_BIT = 1;
   localparam int GDIO_MCU_VEC_CHG_BIT = 0;
   localparam logic [7:0] GDIO_MCU_RW_MASK = 8'h93;
   localparam logic [7:0] GDIO_MCU_RESET = 8'h00;
   localparam logic [7:0] GDIO_LATCH_RESET = 8'h00;
   localparam logic [7:0] GDIO_DIR_RESET = 8'h00;

   // One-hot register select
   typedef enum logic [8:0] {
      GDIO_SEL_NONE = 9'h001,
      GDIO_SEL_LATCH = 9'h002,
      GDIO_SEL_DIR = 9'h004,
      GDIO_SEL_INPUT = 9'h008,
      GDIO_SEL_LSET = 9'h010,
      GDIO_SEL_LCLR = 9'h020,
      GDIO_SEL_DSET = 9'h040,
      GDIO_SEL_DCLR = 9'h080,
      GDIO_SEL_MCU = 9'h100
   } gdio_sel_t;

   typedef struct packed {
      gdio_sel_t sel;
      logic [3:0] port;
   } gdio_dec_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [GDIO_ADDR_W-1:0] paddr;
      logic [GDIO_DATA_W-1:0] pwdata;
   } gdio_apb_req_t;

   typedef struct packed {
      logic [GDIO_DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } gdio_apb_rsp_t;

   // Address decode; ports beyond the instance count are unmapped
   function automatic gdio_dec_t gdio_decode(input logic [GDIO_ADDR_W-1:0] addr,
                                             input int nports);
      gdio_dec_t d;
      logic [11:0] off;
      int p;
      d.sel = GDIO_SEL_NONE;
      d.port = 4'h0;
      p = int'(addr[11:5]);
      off = {7'h00, addr[4:0]};
      if (addr == GDIO_OFF_MCU_CONTROL) begin
         d.sel = GDIO_SEL_MCU;
      end else if (p < nports && p < 16) begin
         d.port = addr[8:5];
         case (off)
            GDIO_OFF_LATCH: d.sel = GDIO_SEL_LATCH;
            GDIO_OFF_DIR: d.sel = GDIO_SEL_DIR;
            GDIO_OFF_INPUT: d.sel = GDIO_SEL_INPUT;
            GDIO_OFF_LATCH_SET: d.sel = GDIO_SEL_LSET;
            GDIO_OFF_LATCH_CLR: d.sel = GDIO_SEL_LCLR;
            GDIO_OFF_DIR_SET: d.sel = GDIO_SEL_DSET;
            GDIO_OFF_DIR_CLR: d.sel = GDIO_SEL_DCLR;
            default: d.sel = GDIO_SEL_NONE;
         endcase
      end
      return d;
   endfunction
endpackage

// [rtl/gdio_sync.sv]
// Two stage synchronizer for the asynchronous pin inputs
`timescale 1ns/1ps
module gdio_sync #(
   parameter int WIDTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   import gdio_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } gdio_sync_state_t;

   gdio_sync_state_t st;
   gdio_sync_state_t next_st;

   // First stage feeds only the second, never any logic
   always_comb begin
      next_st.meta = async_in;
      next_st.stable = st.meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign sync_out = st.stable;
endmodule

// [rtl/gdio_pin_cell.sv]
// Combinational control of one port pin: drive, enable and pull-up
`timescale 1ns/1ps
module gdio_pin_cell (
   input wire logic dir,
   input wire logic latch,
   input wire logic pullup_global_disable,
   input wire logic alt_en,
   input wire logic alt_oe,
   input wire logic alt_out,
   output logic drive,
   output logic oe,
   output logic pull_en
);
   import gdio_pkg::*;

   // Alternate function overrides only its own pin
   always_comb begin
      if (alt_en) begin
         oe = alt_oe;
         drive = alt_out;
         pull_en = 1'b0;
      end else begin
         oe = dir;
         drive = dir & latch;
         pull_en = ~dir & latch & ~pullup_global_disable;
      end
   end
endmodule

// [rtl/gdio_port.sv]
// Top of the general digital I/O port block with its APB register slave
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ps
module gdio_port #(
   parameter int NUM_PORTS = gdio_pkg::GDIO_NUM_PORTS,
   parameter int PIN_W = gdio_pkg::GDIO_PIN_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire gdio_pkg::gdio_apb_req_t apb_req,
   output gdio_pkg::gdio_apb_rsp_t apb_rsp,
   input wire logic [NUM_PORTS*PIN_W-1:0] pin_in,
   output logic [NUM_PORTS*PIN_W-1:0] pin_out,
   output logic [NUM_PORTS*PIN_W-1:0] pin_oe,
   output logic [NUM_PORTS*PIN_W-1:0] pin_pullup,
   input wire logic sleep_deep,
   input wire logic [NUM_PORTS*PIN_W-1:0] ext_irq_en,
   input wire logic [NUM_PORTS*PIN_W-1:0] alt_en,
   input wire logic [NUM_PORTS*PIN_W-1:0] alt_oe,
   input wire logic [NUM_PORTS*PIN_W-1:0] alt_out
);
   import gdio_pkg::*;

   localparam int NB = NUM_PORTS * PIN_W;

   typedef struct packed {
      logic [NB-1:0] latch;
      logic [NB-1:0] dir;
      logic [7:0] mcu;
      logic [NB-1:0] pin_out;
      logic [NB-1:0] pin_oe;
      logic [NB-1:0] pin_pullup;
      logic [GDIO_DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } gdio_state_t;

   gdio_state_t st;
   gdio_state_t next_st;

   logic [NB-1:0] sync_q;
   logic [NB-1:0] clamp;
   logic [NB-1:0] in_view;
   logic [NB-1:0] cell_drive;
   logic [NB-1:0] cell_oe;
   logic [NB-1:0] cell_pullup;
   logic pullup_global_disable;
   gdio_dec_t dec;
   logic access;
   logic done;

   // Pin levels cross into the clock domain before anything looks at them
   gdio_sync #(
      .WIDTH(NB)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in(pin_in),
      .sync_out(sync_q)
   );

   // Clamp in deep sleep keeps floating inputs quiet; wake sources stay live
   assign clamp = {NB{sleep_deep}} & ~(ext_irq_en | alt_en);
   assign in_view = sync_q & ~clamp;
   assign pullup_global_disable = st.mcu[GDIO_MCU_PUD_BIT];

   // One cell per pin, all sharing the global pull-up disable
   for (genvar i = 0; i < NB; i++) begin : g_pin
      gdio_pin_cell u_cell (
         .dir(st.dir[i]),
         .latch(st.latch[i]),
         .pullup_global_disable(pullup_global_disable),
         .alt_en(alt_en[i]),
         .alt_oe(alt_oe[i]),
         .alt_out(alt_out[i]),
         .drive(cell_drive[i]),
         .oe(cell_oe[i]),
         .pull_en(cell_pullup[i])
      );
   end

   // Bus decode is taken straight from the held request
   assign dec = gdio_decode(apb_req.paddr, NUM_PORTS);
   assign access = apb_req.psel & apb_req.penable;
   assign done = access & st.pready;

   // Next state: register reads, writes and pin control
   always_comb begin
      int base;
      logic [PIN_W-1:0] wbits;
      logic [PIN_W-1:0] rbits;
      base = int'(dec.port) * PIN_W;
      wbits = apb_req.pwdata[PIN_W-1:0];
      rbits = '0;
      next_st = st;
      // Pins always follow the cells one cycle later, so outputs are flops
      next_st.pin_out = cell_drive;
      next_st.pin_oe = cell_oe;
      next_st.pin_pullup = cell_pullup;
      // One wait state: read data is captured in the first access cycle
      if (access && !st.pready) begin
         next_st.pready = 1'b1;
         next_st.pslverr = (dec.sel == GDIO_SEL_NONE);
         case (dec.sel)
            GDIO_SEL_LATCH: rbits = st.latch[base +: PIN_W];
            GDIO_SEL_DIR: rbits = st.dir[base +: PIN_W];
            GDIO_SEL_INPUT: rbits = in_view[base +: PIN_W];
            default: rbits = '0;
         endcase
         if (dec.sel == GDIO_SEL_MCU) begin
            next_st.prdata = {24'h000000, st.mcu};
         end else begin
            next_st.prdata = '0;
            next_st.prdata[PIN_W-1:0] = rbits;
         end
      end
      // The write takes effect only at the completing edge
      if (done) begin
         next_st.pready = 1'b0;
         next_st.pslverr = 1'b0;
         next_st.prdata = '0;
         if (apb_req.pwrite) begin
            case (dec.sel)
               GDIO_SEL_LATCH: next_st.latch[base +: PIN_W] = wbits;
               GDIO_SEL_DIR: next_st.dir[base +: PIN_W] = wbits;
               // Toggles regardless of direction and stores nothing itself
               GDIO_SEL_INPUT: next_st.latch[base +: PIN_W] =
                  st.latch[base +: PIN_W] ^ wbits;
               GDIO_SEL_LSET: next_st.latch[base +: PIN_W] =
                  st.latch[base +: PIN_W] | wbits;
               GDIO_SEL_LCLR: next_st.latch[base +: PIN_W] =
                  st.latch[base +: PIN_W] & ~wbits;
               GDIO_SEL_DSET: next_st.dir[base +: PIN_W] =
                  st.dir[base +: PIN_W] | wbits;
               GDIO_SEL_DCLR: next_st.dir[base +: PIN_W] =
                  st.dir[base +: PIN_W] & ~wbits;
               GDIO_SEL_MCU: next_st.mcu =
                  apb_req.pwdata[7:0] & GDIO_MCU_RW_MASK;
               default: next_st.mcu = st.mcu;
            endcase
         end
      end
   end

   // Asynchronous reset releases every pin even with the clock stopped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st.latch <= {NUM_PORTS{GDIO_LATCH_RESET}};
         st.dir <= {NUM_PORTS{GDIO_DIR_RESET}};
         st.mcu <= GDIO_MCU_RESET;
         st.pin_out <= '0;
         st.pin_oe <= '0;
         st.pin_pullup <= '0;
         st.prdata <= '0;
         st.pready <= 1'b0;
         st.pslverr <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs come straight from the state flops
   assign apb_rsp.prdata = st.prdata;
   assign apb_rsp.pready = st.pready;
   assign apb_rsp.pslverr = st.pslverr;
   assign pin_out = st.pin_out;
   assign pin_oe = st.pin_oe;
   assign pin_pullup = st.pin_pullup;

   // Checks on pin control, register effects and bus timing
   logic wr_done;
   logic [NB-1:0] port_mask;
   assign wr_done = done & apb_req.pwrite;
   always_comb begin
      port_mask = '0;
      port_mask[int'(dec.port) * PIN_W +: PIN_W] = {PIN_W{1'b1}};
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_oe_follows_dir: assert property (
      ((pin_oe & ~$past(alt_en)) == ($past(st.dir) & ~$past(alt_en))))
      else $error("Output enable does not follow direction");
   a_pullup_table: assert property (
      (pin_pullup == ($past(~st.dir & st.latch & ~alt_en) & {NB{~$past(pullup_global_disable)}})))
      else $error("Pull-up differs from configuration table");
   a_drive_level: assert property (
      ((pin_out & pin_oe & ~$past(alt_en)) ==
       ($past(st.latch) & pin_oe & ~$past(alt_en))))
      else $error("Driven level differs from output latch");
   a_global_pud: assert property (
      $past(pullup_global_disable) |-> (pin_pullup == '0))
      else $error("Pull-up active while globally disabled");
   a_toggle_latch: assert property (
      (wr_done && dec.sel == GDIO_SEL_INPUT) |=>
      (st.latch == ($past(st.latch) ^ ($past(port_mask) &
       {NUM_PORTS{$past(apb_req.pwdata[PIN_W-1:0])}}))))
      else $error("Input register write did not toggle latch");
   a_input_nostore: assert property (
      (wr_done && dec.sel == GDIO_SEL_INPUT) |=>
      $stable(st.dir) && $stable(st.mcu))
      else $error("Input register write changed stored state");
   a_set_only_bit: assert property (
      (wr_done && dec.sel == GDIO_SEL_DSET) |=>
      (st.dir == ($past(st.dir) | ($past(port_mask) &
       {NUM_PORTS{$past(apb_req.pwdata[PIN_W-1:0])}}))) && $stable(st.latch))
      else $error("Direction set disturbed other pins");
   a_sync_delay: assert property (
      $past(presetn, 2) |-> (sync_q == $past(pin_in, 2)))
      else $error("Pin sample not two cycles behind pin");
   a_sleep_clamp: assert property (
      ((in_view & clamp) == '0) && ((in_view & ~clamp) == (sync_q & ~clamp)))
      else $error("Sleep clamp wrong on input view");
   a_apb_answer: assert property (
      (access && !st.pready) |=> st.pready ##1 !st.pready)
      else $error("APB answer not one wait state");
   a_reset_release: assert property (
      @(posedge pclk) disable iff (1'b0) !presetn |-> (pin_oe == '0 && pin_pullup == '0))
      else $error("Pins not tri-stated during reset");

   c_toggle_write: cover property (wr_done && dec.sel == GDIO_SEL_INPUT);
   c_pullup_on: cover property (pin_pullup != '0);
   c_unmapped: cover property (st.pready && st.pslverr);
   c_sleep_clamp: cover property (clamp != '0 && sync_q != '0);
endmodule

// [test/gdio_board.sv]
// Board model that resolves each pin level from device and external drivers
`timescale 1ns/1ps
module gdio_board #(
   parameter int W = 16
) (
   input wire logic pclk,
   input wire logic [W-1:0] pin_out,
   input wire logic [W-1:0] pin_oe,
   input wire logic [W-1:0] pin_pullup,
   input wire logic [W-1:0] ext_en,
   input wire logic [W-1:0] ext_val,
   output logic [W-1:0] pin_level
);
   logic [W-1:0] noise = '0;
   // A floating pin wanders, so nobody may rely on its last level
   always @(posedge pclk) begin
      noise <= ~noise;
   end
   // Device driver first, then the board driver, then the pull-up
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
      | (~pin_oe & ~ext_en & pin_pullup) | (~pin_oe & ~ext_en & ~pin_pullup & noise);
endmodule

// [test/tb_top.sv]
// Self-checking bench for the general digital I/O port
`timescale 1ns/1ps
module tb_top;
   import gdio_pkg::*;
   localparam int W = 16;
   logic pclk, presetn, sleep_deep, pullup_global_disable;
   gdio_apb_req_t req;
   gdio_apb_rsp_t rsp;
   logic [W-1:0] pin_in, pin_out, pin_oe, pin_pullup, ext_en, ext_val;
   logic [W-1:0] ext_irq_en, alt_en, alt_oe, alt_out, lat, dir, oe_e, out_e, pu_e;
   logic [33:0] q[$];
   logic [33:0] e;
   logic [31:0] rs;
   logic [11:0] b;
   int n_mismatch, tests_run, p;

   gdio_port dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .sleep_deep(sleep_deep), .ext_irq_en(ext_irq_en), .alt_en(alt_en),
      .alt_oe(alt_oe), .alt_out(alt_out));
   gdio_board #(.W(W)) board (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));

   // Free-running 100 MHz clock
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // APB master: setup, access held until pready, then release and idle one cycle
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [31:0] exp, input logic err);
      int n;
      q.push_back({wr, err, exp});
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (n == 20) n_mismatch++;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      @(posedge pclk);
   endtask

   // Each answer is matched against the oldest note
   always @(posedge pclk) begin
      if (rsp.pready === 1'b1 && q.size() > 0) begin
         e = q.pop_front();
         if (!e[33]) cmp(rsp.prdata, e[31:0]);
         cmp({31'h0, rsp.pslverr}, {31'h0, e[32]});
      end
   end

   // Pins are registered, so two edges pass before they are judged
   task automatic chk_pins();
      oe_e = (alt_en & alt_oe) | (~alt_en & dir);
      out_e = (alt_en & alt_out) | (~alt_en & dir & lat);
      pu_e = ~alt_en & ~dir & lat & {W{~pullup_global_disable}};
      ext_en <= ~(oe_e | pu_e);
      repeat (2) @(posedge pclk);
      #1;
      cmp(32'(pin_oe), 32'(oe_e));
      cmp(32'(pin_out), 32'(out_e));
      cmp(32'(pin_pullup), 32'(pu_e));
      @(posedge pclk);
   endtask

   task automatic rd_in(input int pt);
      logic [W-1:0] lv;
      lv = (oe_e & out_e) | (~oe_e & pu_e) | (~oe_e & ~pu_e & ext_val);
      if (sleep_deep) lv = lv & (ext_irq_en | alt_en);
      apb(0, 12'(pt * 32) + GDIO_OFF_INPUT, 0, 32'(lv[pt*8+:8]), 0);
   endtask

   // Main sequence
   initial begin
      n_mismatch = 0;
      tests_run = 0;
      rs = 32'h51b3bdff;
      presetn = 0;
      req = '0;
      {sleep_deep, pullup_global_disable, ext_irq_en, alt_en, alt_oe, alt_out, ext_en, ext_val} = '0;
      {lat, dir} = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_pins();
      for (int i = 0; i < 2; i++) begin
         apb(0, 12'(i * 32) + GDIO_OFF_LATCH, 0, 0, 0);
         apb(0, 12'(i * 32) + GDIO_OFF_DIR, 0, 0, 0);
      end
      apb(0, GDIO_OFF_MCU_CONTROL, 0, 0, 0);
      apb(1, 12'h01c, 32'hff, 0, 1);
      apb(0, 12'h040, 0, 0, 1);
      for (int k = 0; k < 24; k++) begin
         p = k % 2;
         b = 12'(p * 32);
         rs = lfsr(rs);
         ext_val <= rs[15:0];
         alt_en <= (k > 15) ? rs[31:16] : '0;
         rs = lfsr(rs);
         alt_oe <= rs[15:0];
         alt_out <= rs[31:16];
         rs = lfsr(rs);
         ext_irq_en <= rs[15:0];
         sleep_deep <= rs[16];
         // One register per write never jumps a pin between 00 and 11 or 01 and 10
         rs = lfsr(rs);
         lat[p*8+:8] = rs[7:0];
         apb(1, b + GDIO_OFF_LATCH, rs, 0, 0);
         rs = lfsr(rs);
         dir[p*8+:8] = rs[7:0];
         apb(1, b + GDIO_OFF_DIR, rs, 0, 0);
         rs = lfsr(rs);
         pullup_global_disable = rs[4];
         apb(1, GDIO_OFF_MCU_CONTROL, rs, 0, 0);
         apb(0, GDIO_OFF_MCU_CONTROL, 0, {24'h0, rs[7:0] & GDIO_MCU_RW_MASK}, 0);
         rs = lfsr(rs);
         lat[p*8+:8] = lat[p*8+:8] ^ rs[7:0];
         apb(1, b + GDIO_OFF_INPUT, rs, 0, 0);
         rs = lfsr(rs);
         case (rs[9:8])
            2'd0: lat[p*8+:8] = lat[p*8+:8] | rs[7:0];
            2'd1: lat[p*8+:8] = lat[p*8+:8] & ~rs[7:0];
            2'd2: dir[p*8+:8] = dir[p*8+:8] | rs[7:0];
            default: dir[p*8+:8] = dir[p*8+:8] & ~rs[7:0];
         endcase
         apb(1, b + 12'h00c + {8'h0, rs[9:8], 2'b00}, rs, 0, 0);
         apb(0, b + 12'h00c + {8'h0, rs[9:8], 2'b00}, 0, 0, 0);
         apb(0, b + GDIO_OFF_LATCH, 0, 32'(lat[p*8+:8]), 0);
         apb(0, b + GDIO_OFF_DIR, 0, 32'(dir[p*8+:8]), 0);
         chk_pins();
         rd_in(p);
      end
      // Reset strikes between edges; pins must let go without a clock
      #3;
      presetn = 0;
      #1;
      cmp({pin_oe, pin_out}, 0);
      cmp(32'(pin_pullup), 0);
      {lat, dir, pullup_global_disable} = '0;
      @(posedge pclk);
      alt_en <= '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk_pins();
      apb(0, 12'h020 + GDIO_OFF_LATCH, 0, 0, 0);
      apb(0, 12'h020 + GDIO_OFF_DIR, 0, 0, 0);
      cmp(32'(q.size()), 0);
      test_done();
   end

   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      test_done();
   end
endmodule
